// *** src/drpor_cfg.svh ***
`ifndef DRPOR_CFG_SVH
`define DRPOR_CFG_SVH

// Hold interval after a rail recovers, in microseconds
`define DRPOR_HOLD_US      180000
// Clock period in picoseconds (40 MHz)
`define DRPOR_CLK_PS       25000
// Hold interval in clock cycles: 180 ms at 25 ns
// Worked in nanoseconds so every term stays inside 32 bits
`define DRPOR_HOLD_CYC     ((`DRPOR_HOLD_US * 1000) / (`DRPOR_CLK_PS / 1000))
`define DRPOR_CNT_W        23
`define DRPOR_RST_ASSERT   1'h0
`define DRPOR_RST_RELEASE  1'h1
// Synchroniser reset value: main pin idles high, rail flags low
`define DRPOR_SYNC_IDLE    3'h4
// Main pin enable under reset: device pulls the pin low
`define DRPOR_OE_DRIVE     1'h1

`endif

// *** src/drpor_pkg.sv ***
`include "drpor_cfg.svh"

package drpor_pkg;

  typedef enum logic [1:0] {
    DRPOR_HOLD_LOW,
    DRPOR_COUNTING,
    DRPOR_RELEASED
  } drpor_state_t;

endpackage

// *** src/drpor_sync.sv ***
`timescale 1ns/1ps

module drpor_sync
#(
  parameter int WIDTH = 3
)
(
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  input  wire logic [WIDTH-1:0] rst_val_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  // Two-flop synchroniser; stage1 is seen only by stage2
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      stage1_reg <= rst_val_i;
      stage2_reg <= rst_val_i;
    end
    else
    begin
      stage1_reg <= async_i;
      stage2_reg <= stage1_reg;
    end
  end

  // Idle value loaded under reset keeps the first reads after reset quiet
  assign sync_o = stage2_reg;

endmodule

// *** src/drpor_top.sv ***
`timescale 1ns/1ps
`include "drpor_cfg.svh"

// Behaviour
// - Standby reset low while standby rail low
// - Standby reset held 180 ms after recovery
// - Main reset low while main rail low
// - Main reset held 180 ms after recovery
// - Main released 180 ms after standby release
// - Low on main reset pin requests reset
module drpor_top
  import drpor_pkg::*;
#(
  parameter int HOLD_CYC = `DRPOR_HOLD_CYC,
  parameter int CNT_W    = `DRPOR_CNT_W
)
(
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic standby_supply_ok_i,
  input  wire logic main_supply_ok_i,
  input  wire logic main_reset_n_i,
  output logic      standby_reset_n_o,
  output logic      main_reset_n_o,
  output logic      main_reset_n_oe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation

  logic [2:0] sync_w;
  logic [1:0] rel_pipe_reg;
  logic       standby_reset_n_reg;
  logic       main_reset_n_reg;
  wire        stby_ok_w;
  wire        main_ok_w;
  wire        own_rel_w;
  wire        ext_req_w;

  // Pin resets to its idle high level, so no false request after reset
  drpor_sync #(.WIDTH(3)) u_sync
  (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   ({main_reset_n_i, main_supply_ok_i, standby_supply_ok_i}),
    .rst_val_i (`DRPOR_SYNC_IDLE),
    .sync_o    (sync_w)
  );

  assign stby_ok_w = sync_w[0];
  assign main_ok_w = sync_w[1];

  // Our own low drive needs two edges to leave the synchroniser after release;
  // reading the pin earlier would re-trigger the hold without end
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      rel_pipe_reg <= '0;
    else
      rel_pipe_reg <= {rel_pipe_reg[0], main_reset_n_reg};
  end

  // Own drive is masked out: the pin is only read while we release it
  assign own_rel_w = main_reset_n_reg & rel_pipe_reg[1];
  assign ext_req_w = ~sync_w[2] & own_rel_w;

  ////////////////////////////////////////////////////////////////////////////
  // Counters

  function automatic logic cnt_full(input logic [CNT_W-1:0] c);
    cnt_full = (c == CNT_W'(HOLD_CYC));
  endfunction

  // Counters saturate at the hold length so a long-good rail never wraps
  function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] c);
    cnt_step = cnt_full(c) ? c : c + CNT_W'(1);
  endfunction

  logic [CNT_W-1:0] stby_cnt_reg;
  logic [CNT_W-1:0] stby_cnt_next;
  logic [CNT_W-1:0] main_cnt_reg;
  logic [CNT_W-1:0] main_cnt_next;
  drpor_state_t     main_state_reg;
  drpor_state_t     main_state_next;

  wire stby_done_w = cnt_full(stby_cnt_reg);
  wire main_done_w = cnt_full(main_cnt_reg);
  wire stby_rel_w  = stby_ok_w & stby_done_w;
  // Main follows the next standby value, so both drop on the same edge
  wire main_go_w   = main_ok_w & stby_rel_w & ~ext_req_w;

  assign stby_cnt_next = stby_ok_w ? cnt_step(stby_cnt_reg) : '0;

  always_comb
  begin
    main_state_next = main_state_reg;
    main_cnt_next   = main_cnt_reg;
    case (main_state_reg)
      DRPOR_HOLD_LOW:
      begin
        main_cnt_next = '0;
        if (main_go_w)
          main_state_next = DRPOR_COUNTING;
      end
      DRPOR_COUNTING:
      begin
        main_cnt_next = cnt_step(main_cnt_reg);
        if (!main_go_w)
          main_state_next = DRPOR_HOLD_LOW;
        else if (main_done_w)
          main_state_next = DRPOR_RELEASED;
      end
      DRPOR_RELEASED:
      begin
        if (!main_go_w)
          main_state_next = DRPOR_HOLD_LOW;
      end
      default:
        main_state_next = DRPOR_HOLD_LOW;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      stby_cnt_reg        <= '0;
      main_cnt_reg        <= '0;
      main_state_reg      <= DRPOR_HOLD_LOW;
      standby_reset_n_reg <= `DRPOR_RST_ASSERT;
      main_reset_n_reg    <= `DRPOR_RST_ASSERT;
    end
    else
    begin
      stby_cnt_reg        <= stby_cnt_next;
      main_cnt_reg        <= main_cnt_next;
      main_state_reg      <= main_state_next;
      standby_reset_n_reg <= stby_rel_w;
      main_reset_n_reg    <= (main_state_next == DRPOR_RELEASED);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs: open-drain main pin, enable high while pulling low

  assign standby_reset_n_o = standby_reset_n_reg;
  assign main_reset_n_o    = main_reset_n_reg;

  logic main_oe_reg;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      main_oe_reg <= `DRPOR_OE_DRIVE;
    else
      main_oe_reg <= (main_state_next != DRPOR_RELEASED);
  end
  assign main_reset_n_oe_o = main_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Reference run counters, kept apart from the hold logic they judge
  function automatic logic [CNT_W-1:0] run_step(input logic on, input logic [CNT_W-1:0] c);
    if (!on)
      run_step = '0;
    else if (c > CNT_W'(HOLD_CYC))
      run_step = c;
    else
      run_step = c + CNT_W'(1);
  endfunction

  logic [CNT_W-1:0] stby_run_reg;
  logic [CNT_W-1:0] srel_run_reg;
  logic [CNT_W-1:0] mok_run_reg;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      stby_run_reg <= '0;
      srel_run_reg <= '0;
      mok_run_reg  <= '0;
    end
    else
    begin
      stby_run_reg <= run_step(stby_ok_w, stby_run_reg);
      srel_run_reg <= run_step(standby_reset_n_reg, srel_run_reg);
      mok_run_reg  <= run_step(main_ok_w, mok_run_reg);
    end
  end

  wire stby_aged_w = (stby_run_reg > CNT_W'(HOLD_CYC));
  wire srel_aged_w = (srel_run_reg > CNT_W'(HOLD_CYC));
  wire mok_aged_w  = (mok_run_reg > CNT_W'(HOLD_CYC));

  stby_low_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !stby_ok_w |=> !standby_reset_n_o)
    else $error("standby reset released while rail low");

  stby_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(standby_reset_n_o) |-> stby_cnt_reg == CNT_W'(HOLD_CYC))
    else $error("standby reset released before hold elapsed");

  main_low_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !main_ok_w |=> !main_reset_n_o)
    else $error("main reset released while rail low");

  main_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(main_reset_n_o) |-> $past(main_cnt_reg) == CNT_W'(HOLD_CYC))
    else $error("main reset released before hold elapsed");

  main_order_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    main_reset_n_o |-> standby_reset_n_o)
    else $error("main reset released while standby held");

  ext_req_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ext_req_w |=> !main_reset_n_o ##1 !main_reset_n_o)
    else $error("external reset request ignored");

  oe_match_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    main_reset_n_oe_o == !main_reset_n_o)
    else $error("main pin enable disagrees with level");

  sync_lat_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !standby_supply_ok_i [*3] |=> !standby_reset_n_o)
    else $error("standby rail loss not seen in time");

  stby_age_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    standby_reset_n_o == stby_aged_w)
    else $error("standby reset release time wrong");

  main_age_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    main_reset_n_o |-> mok_aged_w)
    else $error("main reset released too soon after rail");

  order_age_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    main_reset_n_o |-> srel_aged_w)
    else $error("main reset released too soon after standby");

  stby_rel_c: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(standby_reset_n_o));
  main_rel_c: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(main_reset_n_o));
  ext_req_c:  cover property (@(posedge clk_i) disable iff (sys_rst_i)
    main_reset_n_o ##1 ext_req_w);
  brown_c:    cover property (@(posedge clk_i) disable iff (sys_rst_i)
    main_reset_n_o ##1 !stby_ok_w);

endmodule

// *** dv/drpor_sys_model.sv ***
`timescale 1ns/1ps

// System side of the main reset wire: 100k pull-up, optional pull-down
module drpor_sys_model
(
  input  wire logic oe_i,
  input  wire logic pull_i,
  output logic      pin_o
);
  // Either party pulling low wins; pull-up otherwise
  assign pin_o = (oe_i | pull_i) ? 1'h0 : 1'h1;
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/1ps

module tb_top;
  import drpor_pkg::*;
  localparam int HOLD = 20;
  logic clk_i     = 1'h0;
  logic sys_rst_i = 1'h1;
  logic sb_ok     = 1'h0;
  logic mn_ok     = 1'h0;
  logic ext_pull  = 1'h0;
  logic pin_lvl;
  logic sb_n;
  logic mn_n;
  logic mn_oe;
  int   n_fail    = 0;
  int   compares  = 0;
  int   n;

  drpor_top #(.HOLD_CYC(HOLD), .CNT_W(8)) i_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .standby_supply_ok_i(sb_ok),
    .main_supply_ok_i(mn_ok), .main_reset_n_i(pin_lvl), .standby_reset_n_o(sb_n),
    .main_reset_n_o(mn_n), .main_reset_n_oe_o(mn_oe));
  drpor_sys_model i_sys (.oe_i(mn_oe), .pull_i(ext_pull), .pin_o(pin_lvl));

  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [2:0] seen, input logic [2:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Synchroniser latency gives a few edges of slack on the hold
  function automatic logic in_win(input int c);
    return (c >= HOLD) && (c <= HOLD + 5);
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_i);
  endtask
  task automatic wait_rel(input bit mn, output int c);
    c = 0;
    while (((mn ? mn_n : sb_n) !== 1'h1) && (c < 4 * HOLD))
    begin
      cyc(1);
      c++;
    end
  endtask
  task automatic print_verdict();
    $display("n_fail=%0d compares=%0d", n_fail, compares);
    if (n_fail == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(5000);
    n_fail++;
    print_verdict();
  end

  initial
  begin
    void'($urandom(32'h5349));
    cyc(12);
    chk({sb_n, mn_n, mn_oe}, 3'h1);
    sys_rst_i = 1'h0;
    cyc(30);
    chk({sb_n, mn_n, mn_oe}, 3'h1);
    sb_ok = 1'h1;
    mn_ok = 1'h1;
    wait_rel(1'b0, n);
    chk({2'h0, in_win(n)}, 3'h1);
    chk({2'h0, mn_n}, 3'h0);
    wait_rel(1'b1, n);
    chk({2'h0, in_win(n)}, 3'h1);
    chk({sb_n, mn_n, mn_oe}, 3'h6);
    mn_ok = 1'h0;
    cyc(5);
    chk({sb_n, mn_n, mn_oe}, 3'h5);
    mn_ok = 1'h1;
    wait_rel(1'b1, n);
    chk({2'h0, in_win(n)}, 3'h1);
    ext_pull = 1'h1;
    cyc(5);
    chk({sb_n, mn_n, mn_oe}, 3'h5);
    ext_pull = 1'h0;
    wait_rel(1'b1, n);
    chk({2'h0, in_win(n)}, 3'h1);
    sb_ok = 1'h0;
    cyc(5);
    chk({sb_n, mn_n, mn_oe}, 3'h1);
    sb_ok = 1'h1;
    wait_rel(1'b0, n);
    wait_rel(1'b1, n);
    chk({2'h0, in_win(n)}, 3'h1);
    // Random rail glitches and pin pulls; ordering must hold every cycle
    repeat (12)
    begin
      sb_ok    = 1'($urandom);
      mn_ok    = 1'($urandom);
      ext_pull = 1'($urandom);
      repeat ($urandom_range(1, 60))
      begin
        cyc(1);
        chk({1'h0, ~mn_n | sb_n, mn_oe ^ mn_n}, 3'h3);
      end
    end
    print_verdict();
  end
endmodule
